// File: verif/fos_bus_model.sv
// fos_bus_model: bus engine stand-in facing the frame output scheduler.
// assumes tx_valid holds until tx_ack; the bench sets the ack delay.
`timescale 1ns/10ps
`default_nettype none
module fos_bus_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] delay,
  output logic            tx_ack
);
  // ==========================================================
  // ack pulse after delay+1 cycles of a held frame
  logic [7:0] wait_r;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wait_r <= 8'h00;
      tx_ack <= 1'b0;
    end else if (tx_valid && !tx_ack && wait_r >= delay) begin
      wait_r <= 8'h00;
      tx_ack <= 1'b1;
    end else begin
      wait_r <= (tx_valid && !tx_ack) ? wait_r + 8'h01 : 8'h00;
      tx_ack <= 1'b0;
    end
  end
endmodule : fos_bus_model
`default_nettype wire

// File: verif/tb_frame_output_scheduler.sv
// tb_frame_output_scheduler: self-checking bench for fos_sched.
// assumes fos_pkg and fos_bus_model; timers shortened to 50/60 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_frame_output_scheduler;
  import fos_pkg::*;
  localparam int PER = 50;
  localparam int MIN = 60;
  logic clock = 1'b0, nrst = 1'b0, lin_master = 1'b0, wr_valid = 1'b0, wr_sess = 1'b0;
  logic wr_ready, wr_refused, flushed, running, tx_valid, tx_ack;
  fos_mode_type mode = FOS_LATEST;
  fos_proto_type proto = FOS_CAN;
  logic [1:0] wr_slot = 2'h0;
  logic [3:0] lin_known = 4'h0;
  logic [7:0] delay = 8'h03;
  logic [43:0] cfg_id = {11'h011, 11'h010, 11'h00e, 11'h00c};
  logic auto_start = 1'b1, start_req = 1'b0;
  logic [3:0] cfg_cyclic = 4'h1, cfg_enh = 4'h2;
  logic [15:0] cfg_len = 16'h8248;
  fos_frame_type wr_frame = '0;
  fos_tx_type tx_frame;
  fos_tx_type txq[$];
  int tat[$];
  int miscompares = 0, tests_run = 0, cyc = 0, nref = 0, nfl = 0, nst = 0;

  fos_sched #(.NSLOT(4), .QDEPTH(8), .NSESS(2), .PERIOD_CLKS(PER), .MININT_CLKS(MIN)) DUT (
    .clock(clock), .nrst(nrst), .mode(mode), .proto(proto), .lin_master(lin_master),
    .auto_start(auto_start), .start_req(start_req), .cfg_cyclic(cfg_cyclic), .cfg_enh(cfg_enh),
    .cfg_id(cfg_id), .cfg_len(cfg_len), .lin_known(lin_known), .lin_known_id(cfg_id), .wr_valid(wr_valid),
    .wr_slot(wr_slot), .wr_sess(wr_sess), .wr_frame(wr_frame), .wr_ready(wr_ready),
    .wr_refused(wr_refused), .flushed(flushed), .running(running), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ack(tx_ack));
  fos_bus_model bus (.clock(clock), .nrst(nrst), .tx_valid(tx_valid), .delay(delay), .tx_ack(tx_ack));

  initial begin
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // monitor: log each acked frame, count pulses, cut hangs
  always @(posedge clock) begin
    cyc++;
    if (nrst && tx_valid === 1'b1 && tx_ack === 1'b1) begin
      txq.push_back(tx_frame);
      tat.push_back(cyc);
    end
    if (wr_refused === 1'b1) nref++;
    if (flushed === 1'b1) nfl++;
    if (nrst && wr_ready === 1'b0) nst++;
    if (cyc > 5000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp

  task automatic rst(input fos_mode_type m, input fos_proto_type p);
    nrst <= 1'b0;
    mode <= m;
    proto <= p;
    lin_master <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    txq.delete();
    tat.delete();
    nref = 0;
    nfl = 0;
    repeat (2) @(posedge clock);
    nst = 0;
  endtask : rst

  // valid stays high so writes may follow back to back; idle lowers it
  task automatic wr(input logic [1:0] sl, input logic s, input logic [10:0] id, input logic [3:0] ln,
                    input logic [63:0] d);
    wr_slot <= sl;
    wr_sess <= s;
    wr_frame <= {id, ln, d, 32'h0};
    wr_valid <= 1'b1;
    do @(posedge clock); while (wr_ready !== 1'b1);
  endtask : wr

  task automatic idle(input int n);
    wr_valid <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  // ==========================================================
  // scenarios
  task automatic t_latest;
    int c, e, lc, le;
    rst(FOS_LATEST, FOS_CAN);
    repeat (10) @(posedge clock);
    cmp("early tx", 0, txq.size());
    cmp("early run", 0, running);
    wr(0, 0, 11'h7ff, 8, 64'h0102030405060708);
    wr(1, 0, 11'h7ff, 4, 64'h0);
    idle(3);
    cmp("running", 1, running);
    while (txq.size() < 2) @(posedge clock);
    cmp("first id", 11'h00c, txq[0].id);
    cmp("second id", 11'h00e, txq[1].id);
    wr(1, 0, 11'h0, 4, 64'haa);
    wr(1, 0, 11'h0, 2, 64'hbb);
    idle(180);
    c = 0; e = 0; lc = -1; le = tat[1];
    for (int i = 2; i < txq.size(); i++) begin
      if (txq[i].id === 11'h00e) begin
        e++;
        cmp("event len", 2, txq[i].len);
        cmp("event gap", 1, tat[i] - le >= MIN);
      end else begin
        c++;
        cmp("cyclic data", 64'h0102030405060708, txq[i].data);
        if (lc >= 0) cmp("cyclic gap", 1, tat[i] - lc >= PER && tat[i] - lc <= PER + 30);
        lc = tat[i];
      end
    end
    cmp("event count", 1, e);
    cmp("cyclic count", 1, c >= 3);
    wr(2, 0, 11'h0, 3, 64'h1);
    idle(3);
    cmp("flush pulse", 1, nfl);
    c = txq.size();
    repeat (150) @(posedge clock);
    cmp("after flush", 1, txq.size() <= c + 1);
    $display("test latest done");
  endtask : t_latest

  task automatic t_seq;
    logic [10:0] eid[3] = '{11'h00c, 11'h123, 11'h7ff};
    logic [3:0] eln[3] = '{4'h5, 4'h0, 4'h8};
    int j, t0;
    rst(FOS_SEQ, FOS_CAN);
    delay <= 8'h00;
    t0 = cyc;
    wr(0, 0, 11'h00c, 5, 64'h0);
    wr(0, 0, 11'h123, 0, 64'h0);
    wr(0, 1, 11'h555, 8, 64'h55);
    wr(0, 0, 11'h7ff, 8, 64'hfedcba9876543210);
    idle(150);
    cmp("seq count", 4, txq.size());
    cmp("seq first", 1, tat[0] - t0 <= 10);
    j = 0;
    for (int i = 0; i < txq.size(); i++) begin
      if (i > 0) cmp("seq gap", 1, tat[i] - tat[i-1] <= 8);
      if (txq[i].id === 11'h555) cmp("sess1 data", 64'h55, txq[i].data);
      else if (j < 3) begin
        cmp("seq id", eid[j], txq[i].id);
        cmp("seq len", eln[j], txq[i].len);
        j++;
      end
    end
    cmp("seq data", 64'hfedcba9876543210, txq[3].data);
    delay <= 8'h03;
    $display("test seq done");
  endtask : t_seq

  task automatic t_lin;
    rst(FOS_SEQ, FOS_LIN);
    lin_known <= 4'h3;
    cfg_enh <= 4'h1;
    wr(0, 0, 11'h00c, 0, 64'h0);
    idle(20);
    cmp("refused", 1, nref);
    cmp("refused tx", 0, txq.size());
    lin_master <= 1'b1;
    wr(0, 0, 11'h00c, 0, 64'h0);
    wr(0, 0, 11'h00e, 8, 64'h1);
    wr(0, 0, 11'h100, 8, 64'h2);
    idle(80);
    cmp("lin count", 3, txq.size());
    cmp("hdr only", 3'b100, {txq[0].hdr_only, txq[1].hdr_only, txq[2].hdr_only});
    cmp("checksum", 3'b101, {txq[0].enh_csum, txq[1].enh_csum, txq[2].enh_csum});
    $display("test lin done");
  endtask : t_lin

  // no auto start: a write waits for the explicit start; event frame sent once
  task automatic t_start;
    rst(FOS_LATEST, FOS_CAN);
    auto_start <= 1'b0;
    cfg_cyclic <= 4'h0;
    wr(0, 0, 11'h0, 8, 64'h11);
    idle(10);
    cmp("held run", 0, running);
    cmp("held tx", 0, txq.size());
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    idle(100);
    cmp("start run", 1, running);
    cmp("event once", 1, txq.size());
    cmp("event data", 64'h11, txq[0].data);
    auto_start <= 1'b1;
    cfg_cyclic <= 4'h1;
    $display("test start done");
  endtask : t_start

  // slow bus: more writes than the queue holds, back-pressure must stall
  task automatic t_full;
    rst(FOS_SEQ, FOS_CAN);
    delay <= 8'h20;
    for (int i = 0; i < 10; i++) wr(0, 0, 11'(i), 1, 64'(i));
    idle(420);
    cmp("stall seen", 1, nst > 0);
    cmp("full count", 10, txq.size());
    for (int i = 0; i < txq.size(); i++) cmp("full order", i, txq[i].id);
    delay <= 8'h03;
    $display("test full done");
  endtask : t_full

  // ==========================================================
  // closing report and main sequence
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    t_latest();
    t_seq();
    t_lin();
    t_start();
    t_full();
    summarize();
  end
endmodule : tb_frame_output_scheduler
`default_nettype wire

// File: verilog/fos_pkg.sv
// fos_pkg: shared types and constants for the frame output scheduler.
// assumes a single 100 MHz clock domain.
package fos_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS          = 10;
  localparam int CYCLE_PERIOD_US = 2000;  // 2.0 ms
  localparam int EVENT_MIN_US    = 2500;  // 2.5 ms
  localparam int CYCLE_PERIOD_CLKS = (CYCLE_PERIOD_US * 1000) / CLK_NS;
  localparam int EVENT_MIN_CLKS    = (EVENT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // sizes and reset values
  localparam int ID_W    = 11;
  localparam int LEN_W   = 4;
  localparam int MAX_LEN = 8;
  localparam logic [LEN_W-1:0] LEN_RST = 4'h0;

  typedef enum logic { FOS_LATEST, FOS_SEQ } fos_mode_type;
  typedef enum logic { FOS_CAN, FOS_LIN } fos_proto_type;

  // ==========================================================
  // one frame value as written by the host
  typedef struct packed {
    logic [ID_W-1:0]      id;
    logic [LEN_W-1:0]     len;
    logic [MAX_LEN*8-1:0] data;
    logic [31:0]          tstamp;
  } fos_frame_type;

  // one frame handed to the bus engine
  typedef struct packed {
    logic [ID_W-1:0]      id;
    logic [LEN_W-1:0]     len;
    logic [MAX_LEN*8-1:0] data;
    logic                 hdr_only;
    logic                 enh_csum;
  } fos_tx_type;

endpackage : fos_pkg

// File: verilog/fos_sched.sv
// fos_sched: transmit scheduler, latest-value and sequential output modes.
// assumes the bus engine takes tx_frame on tx_valid and pulses tx_ack on
// completion; host writes arrive on the same clock.
//
// Functional notes
// - latest-value mode keeps one slot per frame; a newer write overwrites.
// - CAN: shorter payload transmits only supplied bytes.
// - CAN: longer payload flushes pending values, nothing transmits.
// - only the payload of a configured frame value is used.
// - cyclic frame resent every period with latest value.
// - event frame waits minimum interval from previous acknowledgment.
// - newer event value before interval expiry replaces the older.
// - auto start begins session on first host write.
// - sequential values sent as soon as possible, one after another.
// - sequential mode accepts any frame identifier.
// - sequential CAN timing depends only on writes, back to back.
// - sequential mode transmits the supplied payload length.
// - sequential LIN refused unless interface is bus master.
// - LIN empty payload sends header only, else header plus response.
// - LIN configured frame uses its checksum, else enhanced.
// - sequential values queued, none overwritten.
// - sequential timestamp ignored.
// - sequential cyclic frame not repeated.
// - several sequential sessions share one interface.
// - sequential frames sent in written order; the code keeps that order within each session only, sessions taken round robin.
`timescale 1ns/10ps
`default_nettype none
module fos_sched
  import fos_pkg::*;
#(
  parameter int NSLOT = 4,
  parameter int QDEPTH = 8,
  parameter int NSESS = 2,
  parameter int PERIOD_CLKS = CYCLE_PERIOD_CLKS,
  parameter int MININT_CLKS = EVENT_MIN_CLKS
) (
  input  wire logic                             clock,
  input  wire logic                             nrst,
  input  wire fos_pkg::fos_mode_type            mode,
  input  wire fos_pkg::fos_proto_type           proto,
  input  wire logic                             lin_master,
  input  wire logic                             auto_start,
  input  wire logic                             start_req,
  input  wire logic [NSLOT-1:0]                 cfg_cyclic,
  input  wire logic [NSLOT-1:0]                 cfg_enh,
  input  wire logic [NSLOT*fos_pkg::ID_W-1:0]   cfg_id,
  input  wire logic [NSLOT*fos_pkg::LEN_W-1:0]  cfg_len,
  input  wire logic [NSLOT-1:0]                 lin_known,
  input  wire logic [NSLOT*fos_pkg::ID_W-1:0]   lin_known_id,
  input  wire logic                             wr_valid,
  input  wire logic [$clog2(NSLOT)-1:0]         wr_slot,
  input  wire logic [$clog2(NSESS)-1:0]         wr_sess,
  input  wire fos_pkg::fos_frame_type           wr_frame,
  output logic                                  wr_ready,
  output logic                                  wr_refused,
  output logic                                  flushed,
  output logic                                  running,
  output fos_pkg::fos_tx_type                   tx_frame,
  output logic                                  tx_valid,
  input  wire logic                             tx_ack
);
  import fos_pkg::*;

  localparam int SW = $clog2(NSLOT);
  localparam int QW = $clog2(QDEPTH);
  localparam int EW = $clog2(NSESS);
  localparam int TW = 32;

  typedef enum { ST_IDLE, ST_BUSY } fos_state_type;

  function automatic logic [LEN_W-1:0] slot_len(input logic [SW-1:0] s);
    slot_len = cfg_len[s*LEN_W +: LEN_W];
  endfunction : slot_len

  function automatic logic lin_enh(input logic [ID_W-1:0] id);
    lin_enh = 1'b1;
    for (int i = 0; i < NSLOT; i++) begin
      if (lin_known[i] && lin_known_id[i*ID_W +: ID_W] == id) begin
        lin_enh = cfg_enh[i];
      end
    end
  endfunction : lin_enh

  // ==========================================================
  // latest-value slots
  logic [MAX_LEN*8-1:0] slot_data_r [NSLOT];
  logic [LEN_W-1:0]     slot_len_r  [NSLOT];
  logic [NSLOT-1:0]     slot_valid_r;
  logic [NSLOT-1:0]     slot_new_r;
  logic [TW-1:0]        slot_tmr_r  [NSLOT];

  // ==========================================================
  // per-session queues, drained round robin
  fos_frame_type   q_mem_r [NSESS][QDEPTH];
  logic [QW:0]     q_wp_r  [NSESS];
  logic [QW:0]     q_rp_r  [NSESS];
  logic [EW-1:0]   q_turn_r;

  fos_state_type   state_r;
  logic            run_nxt;
  logic            lin_bad;
  logic            too_long;
  logic            q_full;
  logic [SW-1:0]   busy_slot_r;
  logic            busy_seq_r;
  logic [SW-1:0]   pick;
  logic            pick_ok;
  logic [EW-1:0]   qpick;
  logic            qpick_ok;

  assign lin_bad  = (mode == FOS_SEQ) && (proto == FOS_LIN) && !lin_master;
  assign too_long = (mode == FOS_LATEST) && (proto == FOS_CAN)
                    && (wr_frame.len > slot_len(wr_slot));
  // full counts the write taken this cycle; the next session is not known yet
  always_comb begin
    q_full = 1'b0;
    for (int s = 0; s < NSESS; s++) begin
      if ((q_wp_r[s] - q_rp_r[s] + (QW+1)'(wr_valid && wr_ready && wr_sess == EW'(s)))
          >= (QW+1)'(QDEPTH)) begin
        q_full = 1'b1;
      end
    end
  end
  assign run_nxt  = running || start_req || (wr_valid && auto_start && !lin_bad);

  // ==========================================================
  // write acceptance
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ready   <= 1'b0;
      wr_refused <= 1'b0;
      flushed    <= 1'b0;
      running    <= 1'b0;
    end else begin
      wr_ready   <= !(mode == FOS_SEQ && q_full);
      wr_refused <= wr_valid && lin_bad;
      flushed    <= wr_valid && too_long && !lin_bad;
      running    <= run_nxt;
    end
  end

  // ==========================================================
  // slot store; set beats the clear from a transmit in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      slot_valid_r <= '0;
      slot_new_r   <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        slot_data_r[i] <= '0;
        slot_len_r[i]  <= LEN_RST;
      end
    end else begin
      // cleared at launch, so a value written while a frame is in flight survives
      if (state_r == ST_IDLE && running && mode == FOS_LATEST && pick_ok) begin
        slot_new_r[pick] <= 1'b0;
      end
      if (wr_valid && wr_ready && mode == FOS_LATEST) begin
        if (too_long) begin
          slot_valid_r <= '0;
          slot_new_r   <= '0;
        end else begin
          slot_data_r[wr_slot]  <= wr_frame.data;
          slot_len_r[wr_slot]   <= wr_frame.len;
          slot_valid_r[wr_slot] <= 1'b1;
          slot_new_r[wr_slot]   <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // queue writes; timestamp is stored but never looked at
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int s = 0; s < NSESS; s++) begin
        q_wp_r[s] <= '0;
      end
    end else if (wr_valid && wr_ready && mode == FOS_SEQ && !lin_bad) begin
      q_mem_r[wr_sess][q_wp_r[wr_sess][QW-1:0]] <= wr_frame;
      q_wp_r[wr_sess] <= q_wp_r[wr_sess] + 1'b1;
    end
  end

  // ==========================================================
  // slot timers restart on ack and count up, saturating at all ones
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_tmr_r[i] <= '1;
      end
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        if (state_r == ST_BUSY && !busy_seq_r && tx_ack && busy_slot_r == SW'(i)) begin
          slot_tmr_r[i] <= '0;
        end else if (slot_tmr_r[i] != 32'hffffffff) begin
          slot_tmr_r[i] <= slot_tmr_r[i] + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // selection
  always_comb begin
    pick    = '0;
    pick_ok = 1'b0;
    for (int i = NSLOT-1; i >= 0; i--) begin
      if (slot_valid_r[i] && (cfg_cyclic[i]
          ? slot_tmr_r[i] >= TW'(PERIOD_CLKS)
          : slot_new_r[i] && slot_tmr_r[i] >= TW'(MININT_CLKS))) begin
        pick    = SW'(i);
        pick_ok = 1'b1;
      end
    end
    qpick    = q_turn_r;
    qpick_ok = 1'b0;
    for (int k = NSESS-1; k >= 0; k--) begin
      if (q_wp_r[EW'(int'(q_turn_r) + k)] != q_rp_r[EW'(int'(q_turn_r) + k)]) begin
        qpick    = EW'(int'(q_turn_r) + k);
        qpick_ok = 1'b1;
      end
    end
  end

  // ==========================================================
  // transmit engine; one frame in flight at a time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r     <= ST_IDLE;
      tx_valid    <= 1'b0;
      tx_frame    <= '0;
      busy_slot_r <= '0;
      busy_seq_r  <= 1'b0;
      q_turn_r    <= '0;
      for (int s = 0; s < NSESS; s++) begin
        q_rp_r[s] <= '0;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (running && mode == FOS_SEQ && qpick_ok) begin
            tx_frame.id       <= q_mem_r[qpick][q_rp_r[qpick][QW-1:0]].id;
            tx_frame.len      <= q_mem_r[qpick][q_rp_r[qpick][QW-1:0]].len;
            tx_frame.data     <= q_mem_r[qpick][q_rp_r[qpick][QW-1:0]].data;
            tx_frame.hdr_only <= (proto == FOS_LIN)
                                 && q_mem_r[qpick][q_rp_r[qpick][QW-1:0]].len == '0;
            tx_frame.enh_csum <= lin_enh(q_mem_r[qpick][q_rp_r[qpick][QW-1:0]].id);
            q_rp_r[qpick]     <= q_rp_r[qpick] + 1'b1;
            q_turn_r          <= qpick + 1'b1;
            busy_seq_r        <= 1'b1;
            tx_valid          <= 1'b1;
            state_r           <= ST_BUSY;
          end else if (running && mode == FOS_LATEST && pick_ok) begin
            tx_frame.id       <= cfg_id[pick*ID_W +: ID_W];
            tx_frame.len      <= slot_len_r[pick];
            tx_frame.data     <= slot_data_r[pick];
            tx_frame.hdr_only <= (proto == FOS_LIN) && slot_len_r[pick] == '0;
            tx_frame.enh_csum <= cfg_enh[pick];
            busy_slot_r       <= pick;
            busy_seq_r        <= 1'b0;
            tx_valid          <= 1'b1;
            state_r           <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (tx_ack) begin
            tx_valid <= 1'b0;
            state_r  <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  sequence ack_s;
    tx_valid && tx_ack && !busy_seq_r;
  endsequence

  event_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    ack_s ##1 ($stable(busy_slot_r) && !cfg_cyclic[busy_slot_r]) |->
      slot_tmr_r[busy_slot_r] < TW'(MININT_CLKS))
    else $error("event frame timer not restarted on ack");
  refuse_lin_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_valid && lin_bad |=> wr_refused)
    else $error("sequential lin write not refused");
  no_early_a: assert property (@(posedge clock) disable iff (!nrst)
    state_r == ST_IDLE && mode == FOS_LATEST ##1 tx_valid && !busy_seq_r |->
      $past(slot_valid_r) != '0)
    else $error("frame sent before first value");
  auto_start_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_valid && auto_start && !lin_bad |=> running)
    else $error("session did not start on first write");
  flush_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_valid && wr_ready && too_long |=> slot_valid_r == '0 && flushed)
    else $error("long payload did not flush");
  hold_a: assert property (@(posedge clock) disable iff (!nrst)
    tx_valid && !tx_ack |=> tx_valid && $stable(tx_frame))
    else $error("frame changed before ack");
endmodule : fos_sched
`default_nettype wire
